// ---- hw/sysreg_pkg.sv ----
// Purpose: Shared constants for the virtualized system register bank
// Assumes: 32-bit registers, word-indexed register port
// Notes: Offsets are register indices on the plain register port
package sysreg_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   // Register indices
   localparam logic [4:0] OFF_EI_CAUSE = 5'h00;
   localparam logic [4:0] OFF_FE_CAUSE = 5'h01;
   localparam logic [4:0] OFF_TC_PC = 5'h02;
   localparam logic [4:0] OFF_TC_PSW = 5'h03;
   localparam logic [4:0] OFF_TC_BASE = 5'h04;
   localparam logic [4:0] OFF_EI_WORK = 5'h05;
   localparam logic [4:0] OFF_FE_WORK = 5'h06;
   localparam logic [4:0] OFF_PROT_ID = 5'h07;
   localparam logic [4:0] OFF_PROT_LIST = 5'h08;
   localparam logic [4:0] OFF_RST_BASE = 5'h09;
   localparam logic [4:0] OFF_EXC_BASE = 5'h0A;
   localparam logic [4:0] OFF_INT_BASE = 5'h0B;
   localparam logic [4:0] OFF_IDENT = 5'h0C;
   localparam logic [4:0] OFF_VIRT_CTL = 5'h0D;
   // Control field positions
   localparam int unsigned VIRT_EN_BIT = 0;
   localparam int unsigned GUEST_BIT = 1;
   // Identity field positions
   localparam int unsigned ID_ARCH_LSB = 24;
   localparam int unsigned ID_VER_LSB = 0;
   localparam int unsigned ID_HV_BIT = 23;
   localparam int unsigned ID_RBANK_BIT = 18;
   localparam int unsigned ID_FXU_BIT = 11;
   localparam int unsigned ID_DP_BIT = 10;
   localparam int unsigned ID_SP_BIT = 9;
   localparam int unsigned ID_MPU_BIT = 8;
   // Mask of the implemented function bits; reserved bits stay zero
   localparam logic [31:0] ID_FUNC_MASK = 32'h00840F00;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] RST_BASE_VAL = 32'h00000000;
endpackage

// ---- hw/virtualized_system_regs.sv ----
// Purpose: Host and guest banked CPU system registers with identity word
// Assumes: Core strobes are single-cycle and on the core clock
// Notes: Register port reads return data one cycle after the strobe
//
// What this block does
// [R1] Capture EI exception cause code into the EI cause register.
// [R2] Capture FE exception cause code into the FE cause register.
// [R3] Banked registers reach the host copy in host mode.
// [R4] Banked registers reach the guest copy in guest mode.
// [R5] Table call stores next instruction address into the PC save register.
// [R6] Table call stores selected status word bits into status save.
// [R7] Table call base register drives the table-call table address.
// [R8] EI scratch register readable and writable by handlers.
// [R9] FE scratch register readable and writable by handlers.
// [R10] Protection identifier register holds the current identifier.
// [R11] List register names the legal protection identifier values.
// [R12] Reset vector comes from the single unbanked reset base register.
// [R13] Exception vector base comes from the active mode copy.
// [R14] Interrupt table base of the active mode drives table lookup.
// [R15] Identity register is read-only; writes are ignored.
// [R16] Identity bits 31 to 24 give the architecture identifier.
// [R17] Identity bits 23 to 8 flag implemented functions.
// [R18] Bit 23 virtualization, bit 18 register bank; others reserved zero.
// [R19] Bits 11, 10, 9, 8: extended, double, single float, protection.
// [R20] Identity bits 7 to 0 give the version identifier.
// [R21] Host mode when enabled and guest flag clear; guest when set.
// [R22] Hardware captures also write the copy of the current mode.
`timescale 1ns/1ps
module virtualized_system_regs
   import sysreg_pkg::*;
#(
   parameter logic [7:0] ARCH_ID = 8'h01,      // Arbitrary value
   parameter logic [7:0] VERSION_ID = 8'h01,   // Arbitrary value
   parameter bit HAS_VIRT = 1'b1,
   parameter bit HAS_RBANK = 1'b1,
   parameter bit HAS_FXU = 1'b0,
   parameter bit HAS_DPFPU = 1'b1,
   parameter bit HAS_SPFPU = 1'b1,
   parameter bit HAS_MPU = 1'b1,
   parameter logic [31:0] PSW_SAVE_MASK = 32'h0000001F
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Software register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   // Execution core events
   input wire logic EI_TAKEN,
   input wire logic [31:0] EI_CAUSE,
   input wire logic FE_TAKEN,
   input wire logic [31:0] FE_CAUSE,
   input wire logic TC_EXEC,
   input wire logic [31:0] TC_NEXT_PC,
   input wire logic [31:0] STATUS_WORD,
   // Vectors and bases to the core
   output logic GUEST_MODE,
   output logic [31:0] RESET_VECTOR,
   output logic [31:0] EXC_VECTOR_BASE,
   output logic [31:0] INT_TABLE_BASE,
   output logic [31:0] TC_TABLE_BASE,
   output logic [31:0] PROT_ID,
   output logic [31:0] PROT_ID_LIST
);

   // Copies of one banked register: index 0 host, index 1 guest
   typedef logic [1:0][31:0] bank_t;

   typedef struct packed {
      bank_t ei_cause;
      bank_t fe_cause;
      bank_t ei_work;
      bank_t fe_work;
      bank_t prot_id;
      bank_t prot_list;
      bank_t exc_base;
      bank_t int_base;
      logic [31:0] tc_pc;
      logic [31:0] tc_psw;
      logic [31:0] tc_base;
      logic [31:0] rst_base;
      logic virt_en;
      logic guest_flag;
      logic [31:0] rdata;
      logic guest_mode;
      logic [31:0] reset_vec;
      logic [31:0] exc_vec;
      logic [31:0] int_tab;
      logic [31:0] tc_tab;
      logic [31:0] pid_o;
      logic [31:0] plist_o;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic [31:0] ident;
   logic sel;
   logic sel_next;

   // Identity word is built from parameters only, so no write can move it
   always_comb begin
      ident = RST_ZERO;                                    // see [R18]
      ident[ID_ARCH_LSB +: 8] = ARCH_ID;                   // see [R16]
      ident[ID_VER_LSB +: 8] = VERSION_ID;                 // see [R20]
      ident[ID_HV_BIT] = HAS_VIRT;                         // see [R17]
      ident[ID_RBANK_BIT] = HAS_RBANK;                     // see [R18]
      ident[ID_FXU_BIT] = HAS_FXU;                         // see [R19]
      ident[ID_DP_BIT] = HAS_DPFPU;                        // see [R19]
      ident[ID_SP_BIT] = HAS_SPFPU;                        // see [R19]
      ident[ID_MPU_BIT] = HAS_MPU;                         // see [R19]
   end

   // Guest only when virtualization is on and the guest flag is set
   assign sel = st_q.virt_en & st_q.guest_flag;            // see [R21]

   // Next state: register writes, core captures, read mux, outputs
   always_comb begin
      st_d = st_q;
      // Software accesses to banked registers use the current copy
      if (WR) begin
         unique case (ADDR)
            OFF_EI_CAUSE: st_d.ei_cause[sel] = WDATA;      // see [R3] [R4]
            OFF_FE_CAUSE: st_d.fe_cause[sel] = WDATA;
            OFF_TC_PC: st_d.tc_pc = WDATA;
            OFF_TC_PSW: st_d.tc_psw = WDATA & PSW_SAVE_MASK;
            OFF_TC_BASE: st_d.tc_base = WDATA;
            OFF_EI_WORK: st_d.ei_work[sel] = WDATA;        // see [R8]
            OFF_FE_WORK: st_d.fe_work[sel] = WDATA;        // see [R9]
            OFF_PROT_ID: st_d.prot_id[sel] = WDATA;        // see [R10]
            OFF_PROT_LIST: st_d.prot_list[sel] = WDATA;    // see [R11]
            OFF_RST_BASE: st_d.rst_base = WDATA;           // see [R12]
            OFF_EXC_BASE: st_d.exc_base[sel] = WDATA;
            OFF_INT_BASE: st_d.int_base[sel] = WDATA;
            OFF_VIRT_CTL: begin
               st_d.virt_en = WDATA[VIRT_EN_BIT] & HAS_VIRT;
               st_d.guest_flag = WDATA[GUEST_BIT];
            end
            default: ;                                     // see [R15]
         endcase
      end
      // Core captures come after software so a same-cycle event wins
      if (EI_TAKEN) begin
         st_d.ei_cause[sel] = EI_CAUSE;                    // see [R1] [R22]
      end
      if (FE_TAKEN) begin
         st_d.fe_cause[sel] = FE_CAUSE;                    // see [R2] [R22]
      end
      if (TC_EXEC) begin
         st_d.tc_pc = TC_NEXT_PC;                          // see [R5]
         st_d.tc_psw = STATUS_WORD & PSW_SAVE_MASK;        // see [R6]
      end
      // Read data stand only in the cycle after the strobe
      st_d.rdata = RST_ZERO;
      if (RD) begin
         unique case (ADDR)
            OFF_EI_CAUSE: st_d.rdata = st_q.ei_cause[sel];
            OFF_FE_CAUSE: st_d.rdata = st_q.fe_cause[sel];
            OFF_TC_PC: st_d.rdata = st_q.tc_pc;
            OFF_TC_PSW: st_d.rdata = st_q.tc_psw;
            OFF_TC_BASE: st_d.rdata = st_q.tc_base;
            OFF_EI_WORK: st_d.rdata = st_q.ei_work[sel];
            OFF_FE_WORK: st_d.rdata = st_q.fe_work[sel];
            OFF_PROT_ID: st_d.rdata = st_q.prot_id[sel];
            OFF_PROT_LIST: st_d.rdata = st_q.prot_list[sel];
            OFF_RST_BASE: st_d.rdata = st_q.rst_base;
            OFF_EXC_BASE: st_d.rdata = st_q.exc_base[sel];
            OFF_INT_BASE: st_d.rdata = st_q.int_base[sel];
            OFF_IDENT: st_d.rdata = ident;                 // see [R15]
            OFF_VIRT_CTL: begin
               st_d.rdata[VIRT_EN_BIT] = st_q.virt_en;
               st_d.rdata[GUEST_BIT] = st_q.guest_flag;
            end
            default: st_d.rdata = RST_ZERO;
         endcase
      end
      // Core-facing views follow the mode after this edge's updates
      sel_next = st_d.virt_en & st_d.guest_flag;           // see [R21]
      st_d.guest_mode = sel_next;
      st_d.reset_vec = st_d.rst_base;                      // see [R12]
      st_d.exc_vec = st_d.exc_base[sel_next];              // see [R13]
      st_d.int_tab = st_d.int_base[sel_next];              // see [R14]
      st_d.tc_tab = st_d.tc_base;                          // see [R7]
      st_d.pid_o = st_d.prot_id[sel_next];                 // see [R10]
      st_d.plist_o = st_d.prot_list[sel_next];             // see [R11]
   end

   // All state in one register; reset loads constants only
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= '0;
         st_q.rst_base <= RST_BASE_VAL;
         st_q.reset_vec <= RST_BASE_VAL;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign RDATA = st_q.rdata;
   assign GUEST_MODE = st_q.guest_mode;
   assign RESET_VECTOR = st_q.reset_vec;
   assign EXC_VECTOR_BASE = st_q.exc_vec;
   assign INT_TABLE_BASE = st_q.int_tab;
   assign TC_TABLE_BASE = st_q.tc_tab;
   assign PROT_ID = st_q.pid_o;
   assign PROT_ID_LIST = st_q.plist_o;

endmodule

// ---- tb/virtualized_system_regs_assertions.sv ----
// Purpose: Port checks of the banked system register block
// Assumes: One clock, async active-low reset
// Notes: Captures are read back one cycle later with the mode unchanged
`timescale 1ns/1ps
module virtualized_system_regs_assertions
   import sysreg_pkg::*;
#(
   parameter logic [7:0] ARCH_ID = 8'h01,
   parameter logic [7:0] VERSION_ID = 8'h01,
   parameter bit HAS_VIRT = 1'b1,
   parameter bit HAS_RBANK = 1'b1,
   parameter bit HAS_FXU = 1'b0,
   parameter bit HAS_DPFPU = 1'b1,
   parameter bit HAS_SPFPU = 1'b1,
   parameter bit HAS_MPU = 1'b1,
   parameter logic [31:0] PSW_SAVE_MASK = 32'h0000001F
) (
   // Clock, reset and register port
   input wire logic CLK, RST_N, WR, RD,
   input wire logic [4:0] ADDR,
   input wire logic [31:0] WDATA, RDATA,
   // Core events and views
   input wire logic EI_TAKEN, FE_TAKEN, TC_EXEC, GUEST_MODE,
   input wire logic [31:0] EI_CAUSE, FE_CAUSE, TC_NEXT_PC, STATUS_WORD,
   input wire logic [31:0] RESET_VECTOR, EXC_VECTOR_BASE, INT_TABLE_BASE,
   input wire logic [31:0] TC_TABLE_BASE, PROT_ID, PROT_ID_LIST
);
   // Reserved identity bits must read zero
   localparam logic [31:0] ID_EXP = {ARCH_ID, HAS_VIRT, 4'h0, HAS_RBANK,
      6'h00, HAS_FXU, HAS_DPFPU, HAS_SPFPU, HAS_MPU, VERSION_ID};
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Identity word, also after attempted writes
   a_ident_read: assert property (RD && ADDR == OFF_IDENT |=> RDATA == ID_EXP)
      else $error("identity word wrong");
   // Mode stable between capture and read, so the same copy is seen
   a_ei_capture: assert property (EI_TAKEN ##1 (RD && ADDR == OFF_EI_CAUSE
      && !EI_TAKEN && $stable(GUEST_MODE)) |=> RDATA == $past(EI_CAUSE, 2))
      else $error("EI cause not captured");
   a_fe_capture: assert property (FE_TAKEN ##1 (RD && ADDR == OFF_FE_CAUSE
      && !FE_TAKEN && $stable(GUEST_MODE)) |=> RDATA == $past(FE_CAUSE, 2))
      else $error("FE cause not captured");
   a_tc_pc: assert property (TC_EXEC ##1 (RD && ADDR == OFF_TC_PC && !TC_EXEC)
      |=> RDATA == $past(TC_NEXT_PC, 2)) else $error("table call pc wrong");
   a_tc_status: assert property (TC_EXEC ##1 (RD && ADDR == OFF_TC_PSW
      && !TC_EXEC) |=> RDATA == ($past(STATUS_WORD, 2) & PSW_SAVE_MASK))
      else $error("table call status wrong");
   a_mode_select: assert property (WR && ADDR == OFF_VIRT_CTL |=> GUEST_MODE
      == (HAS_VIRT && ($past(WDATA) & 32'h3) == 32'h3)) else $error("mode wrong");
   a_reset_base: assert property (WR && ADDR == OFF_RST_BASE
      |=> RESET_VECTOR == $past(WDATA)) else $error("reset vector wrong");
   a_tc_base: assert property (WR && ADDR == OFF_TC_BASE ##1
      !(WR && ADDR == OFF_TC_BASE) |=> TC_TABLE_BASE == $past(WDATA, 2))
      else $error("table call base wrong");
   a_exc_base: assert property (WR && ADDR == OFF_EXC_BASE
      |=> EXC_VECTOR_BASE == $past(WDATA)) else $error("vector base wrong");
endmodule
bind virtualized_system_regs virtualized_system_regs_assertions #(
   .ARCH_ID(ARCH_ID), .VERSION_ID(VERSION_ID), .HAS_VIRT(HAS_VIRT),
   .HAS_RBANK(HAS_RBANK), .HAS_FXU(HAS_FXU), .HAS_DPFPU(HAS_DPFPU),
   .HAS_SPFPU(HAS_SPFPU), .HAS_MPU(HAS_MPU), .PSW_SAVE_MASK(PSW_SAVE_MASK)
) i_chk (.*);

// ---- tb/core_model.sv ----
// Purpose: Execution core stand-in raising capture pulses
// Assumes: REQ bit 0 EI, bit 1 FE, bit 2 table call
// Notes: Data outputs toggle outside pulses so stale values never match
`timescale 1ns/1ps
module core_model (
   input wire logic CLK,
   input wire logic [2:0] REQ,
   input wire logic [31:0] VAL,
   output logic EI_TAKEN, FE_TAKEN, TC_EXEC,
   output logic [31:0] EI_CAUSE, FE_CAUSE, TC_NEXT_PC, STATUS_WORD
);
   // Quiet at time zero
   initial begin
      {EI_TAKEN, FE_TAKEN, TC_EXEC} = 3'h0;
      {EI_CAUSE, FE_CAUSE, TC_NEXT_PC, STATUS_WORD} = 128'h0;
   end
   // One-cycle pulse a cycle after each request
   always @(posedge CLK) begin
      {TC_EXEC, FE_TAKEN, EI_TAKEN} <= REQ;
      EI_CAUSE <= REQ[0] ? VAL : ~EI_CAUSE;
      FE_CAUSE <= REQ[1] ? VAL : ~FE_CAUSE;
      TC_NEXT_PC <= REQ[2] ? VAL : ~TC_NEXT_PC;
      STATUS_WORD <= REQ[2] ? ~VAL : ~STATUS_WORD;
   end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Register-call tests of the banked system registers
// Assumes: Tasks are entered just after a rising edge
// Notes: Each strobe task adds one idle cycle, trading speed for no strobe clash
`timescale 1ns/1ps
module testbench;
   import sysreg_pkg::*;
   logic CLK, RST_N, WR, RD;
   logic [4:0] ADDR;
   logic [31:0] WDATA, VAL;
   logic [2:0] REQ;
   wire logic EI_TAKEN, FE_TAKEN, TC_EXEC, GUEST_MODE;
   wire logic [31:0] EI_CAUSE, FE_CAUSE, TC_NEXT_PC, STATUS_WORD, RDATA;
   wire logic [31:0] RESET_VECTOR, EXC_VECTOR_BASE, INT_TABLE_BASE;
   wire logic [31:0] TC_TABLE_BASE, PROT_ID, PROT_ID_LIST;
   int num_errors = 0;
   int check_count = 0;
   logic [4:0] bank [8] = '{OFF_EI_CAUSE, OFF_FE_CAUSE, OFF_EI_WORK,
      OFF_FE_WORK, OFF_PROT_ID, OFF_PROT_LIST, OFF_EXC_BASE, OFF_INT_BASE};
   virtualized_system_regs #(.ARCH_ID(8'hA5), .VERSION_ID(8'h3C),
      .HAS_RBANK(1'b0), .HAS_FXU(1'b1)) i_virtualized_system_regs (.*);
   core_model i_core_model (.*);
   // 40 MHz core clock
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK) WR <= 1'b0;
      @(posedge CLK);
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rdc(logic [4:0] a, logic [31:0] e);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK) RD <= 1'b0;
      #1 chk("read data", e, RDATA);
      @(posedge CLK);
   endtask
   task automatic ev(logic [2:0] k, logic [31:0] v);
      REQ <= k;
      VAL <= v;
      @(posedge CLK) REQ <= 3'h0;
      @(posedge CLK);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge CLK);
      num_errors++;
      report_and_stop();
   end
   initial begin
      {RST_N, WR, RD, ADDR, WDATA, REQ, VAL} = '0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      chk("reset vector", 32'h0, RESET_VECTOR);
      wr(OFF_IDENT, 32'hFFFFFFFF);
      rdc(OFF_IDENT, 32'hA5800F3C);
      rdc(5'h1F, 32'h0);
      $display("identity test done");
      wr(OFF_VIRT_CTL, 32'h1);
      for (int i = 0; i < 8; i++) wr(bank[i], 32'h10000000 + 32'(i));
      wr(OFF_RST_BASE, 32'h00ABC000);
      wr(OFF_TC_BASE, 32'h00001000);
      wr(OFF_VIRT_CTL, 32'h3);
      chk("guest mode", 32'h1, {31'h0, GUEST_MODE});
      for (int i = 0; i < 8; i++) wr(bank[i], 32'h20000000 + 32'(i));
      ev(3'h1, 32'h00000055);
      rdc(OFF_EI_CAUSE, 32'h00000055);
      ev(3'h2, 32'h00000066);
      rdc(OFF_FE_CAUSE, 32'h00000066);
      for (int i = 2; i < 8; i++) rdc(bank[i], 32'h20000000 + 32'(i));
      chk("exc base", 32'h20000006, EXC_VECTOR_BASE);
      chk("int base", 32'h20000007, INT_TABLE_BASE);
      chk("prot id", 32'h20000004, PROT_ID);
      chk("prot list", 32'h20000005, PROT_ID_LIST);
      chk("reset vector", 32'h00ABC000, RESET_VECTOR);
      chk("tc base", 32'h00001000, TC_TABLE_BASE);
      ev(3'h4, 32'h00004000);
      rdc(OFF_TC_PC, 32'h00004000);
      rdc(OFF_TC_PSW, 32'h0000001F);
      $display("guest test done");
      wr(OFF_VIRT_CTL, 32'h1);
      for (int i = 0; i < 8; i++) rdc(bank[i], 32'h10000000 + 32'(i));
      chk("exc base", 32'h10000006, EXC_VECTOR_BASE);
      chk("int base", 32'h10000007, INT_TABLE_BASE);
      wr(OFF_VIRT_CTL, 32'h2);
      chk("guest mode", 32'h0, {31'h0, GUEST_MODE});
      $display("host test done");
      report_and_stop();
   end
endmodule
